// ==== shared/eur_defines.svh ====
`ifndef EUR_DEFINES_SVH
`define EUR_DEFINES_SVH

// Register byte addresses
`define EUR_ADDR_RXSC 8'h00
`define EUR_ADDR_RXDB 8'h04
`define EUR_ADDR_TXSC 8'h08
`define EUR_ADDR_BAUD 8'h0C
`define EUR_ADDR_DIVH 8'h10
`define EUR_ADDR_DIVL 8'h14
`define EUR_ADDR_TXDB 8'h18
`define EUR_ADDR_INTC 8'h1C

// rx_status_control fields
`define EUR_RXSC_SERIAL_PORT_ENABLE  7
`define EUR_RXSC_RX9   6
`define EUR_RXSC_CONTINUOUS_RECEIVE_ENABLE  4
`define EUR_RXSC_ADDRESS_DETECT_ENABLE 3
// tx_status_control fields
`define EUR_TXSC_CSRC  7
`define EUR_TXSC_TX9   6
`define EUR_TXSC_TRANSMIT_ENABLE_BIT  5
`define EUR_TXSC_SYNC  4
`define EUR_TXSC_SEND_BREAK_REQUEST 3
`define EUR_TXSC_BAUD_HIGH_SPEED_SELECT  2
`define EUR_TXSC_TX9D  0
// baud_control fields
`define EUR_BAUD_BAUD_WIDE_GENERATOR_SELECT 3
`define EUR_BAUD_WUE   1
`define EUR_BAUD_AUTOBAUD_DETECT_ENABLE 0
// interrupt control fields
`define EUR_INTC_RXIE  4

// Oversampling: last tick of a 16-tick bit, tick of mid-bit sample
`define EUR_OS_LAST    4'hF
`define EUR_OS_MID     4'h7
// Frame lengths in bits, start and stop included
`define EUR_LEN_BREAK  4'hE
`define EUR_LEN_NINE   4'hB
`define EUR_LEN_EIGHT  4'hA

`endif

// ==== shared/eur_pkg.sv ====
package eur_pkg;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_STOP  = 5'h08,
    RX_WAKE  = 5'h10
  } eur_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_SEND = 2'h2
  } eur_tx_state_t;

  typedef struct packed {
    logic       ninth;
    logic       frameErr;
    logic [7:0] data;
  } eur_rx_word_t;

endpackage

// ==== hdl/eur_uart_top.sv ====
`timescale 1ns/1ps
`include "eur_defines.svh"
module eur_uart_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial lines
  input  wire logic        serialReceiveLine,
  output logic             serialTransmitLine,
  // Receive interrupt request
  output logic             rxInterruptRequest
);

  logic                   serial_port_enable, rx9, continuous_receive_enable, address_detect_enable, overrun_error_flag;
  logic                   csrc, tx9, transmit_enable_bit, sync, send_break_request, baud_high_speed_select, tx9d;
  logic                   baud_wide_generator_select, wake_on_edge_enable, autobaud_detect_enable, rxie;
  logic [7:0]             divHi, divLo, txData;
  logic                   rxFlag, rxFull, txFull;
  eur_pkg::eur_rx_word_t  rxWord;
  logic [15:0]            brgCnt;
  logic [1:0]             preCnt;
  logic                   baseTick, sampleTick;
  logic                   rxMeta, rxSync, rxPrev, fallEdge, riseEdge;
  eur_pkg::eur_rx_state_t rxState;
  logic [3:0]             osCnt, bitCnt;
  logic [8:0]             shiftReg;
  logic                   stopBit, doneStrobe, wakeSeen, wakeEvt, accept, setRx;
  eur_pkg::eur_tx_state_t txState;
  logic [13:0]            txShift;
  logic [3:0]             txOs, txLeft;
  logic                   txIsBreak, txLoad, txBitEnd, breakEnd;
  logic                   setup, access, wrEn, rdEn;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= `EUR_ADDR_INTC);
  endfunction

  // APB: zero-wait answer, data captured in the setup cycle
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wrEn   = access && pwrite && !pslverr;
  assign rdEn   = access && !pwrite && !pslverr;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !isMapped(paddr);
      if (setup) begin
        case (paddr)
          `EUR_ADDR_RXSC: prdata <= {24'h0, serial_port_enable, rx9, 1'b0, continuous_receive_enable, address_detect_enable,
                                     rxWord.frameErr, overrun_error_flag, rxWord.ninth};
          `EUR_ADDR_RXDB: prdata <= {24'h0, rxWord.data};
          `EUR_ADDR_TXSC: prdata <= {24'h0, csrc, tx9, transmit_enable_bit, sync, send_break_request, baud_high_speed_select,
                                     txState == eur_pkg::TX_IDLE, tx9d};
          `EUR_ADDR_BAUD: prdata <= {24'h0, 1'b0, rxState == eur_pkg::RX_IDLE,
                                     2'h0, baud_wide_generator_select, 1'b0, wake_on_edge_enable, autobaud_detect_enable};
          `EUR_ADDR_DIVH: prdata <= {24'h0, divHi};
          `EUR_ADDR_DIVL: prdata <= {24'h0, divLo};
          `EUR_ADDR_TXDB: prdata <= {24'h0, txData};
          `EUR_ADDR_INTC: prdata <= {27'h0, rxie, 2'h0, !txFull, rxFlag};
          default:        prdata <= 32'h0;
        endcase
      end
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {serial_port_enable, rx9, continuous_receive_enable, address_detect_enable} <= 4'h0;
    end else if (wrEn && paddr == `EUR_ADDR_RXSC) begin
      serial_port_enable  <= pwdata[`EUR_RXSC_SERIAL_PORT_ENABLE];
      rx9   <= pwdata[`EUR_RXSC_RX9];
      continuous_receive_enable  <= pwdata[`EUR_RXSC_CONTINUOUS_RECEIVE_ENABLE];
      address_detect_enable <= pwdata[`EUR_RXSC_ADDRESS_DETECT_ENABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {csrc, tx9, transmit_enable_bit, sync, send_break_request, baud_high_speed_select, tx9d} <= 7'h0;
    end else if (wrEn && paddr == `EUR_ADDR_TXSC) begin
      csrc  <= pwdata[`EUR_TXSC_CSRC];
      tx9   <= pwdata[`EUR_TXSC_TX9];
      transmit_enable_bit  <= pwdata[`EUR_TXSC_TRANSMIT_ENABLE_BIT];
      sync  <= pwdata[`EUR_TXSC_SYNC];
      send_break_request <= pwdata[`EUR_TXSC_SEND_BREAK_REQUEST];
      baud_high_speed_select  <= pwdata[`EUR_TXSC_BAUD_HIGH_SPEED_SELECT];
      tx9d  <= pwdata[`EUR_TXSC_TX9D];
    end else if (breakEnd) begin
      send_break_request <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {baud_wide_generator_select, wake_on_edge_enable, autobaud_detect_enable, rxie} <= 4'h0;
      divHi <= 8'h00;
      divLo <= 8'h00;
    end else begin
      if (wrEn && paddr == `EUR_ADDR_BAUD) begin
        baud_wide_generator_select <= pwdata[`EUR_BAUD_BAUD_WIDE_GENERATOR_SELECT];
        wake_on_edge_enable   <= pwdata[`EUR_BAUD_WUE];
        autobaud_detect_enable <= pwdata[`EUR_BAUD_AUTOBAUD_DETECT_ENABLE];
      end else if (rxState == eur_pkg::RX_WAKE && wakeSeen && riseEdge) begin
        wake_on_edge_enable <= 1'b0;
      end
      if (wrEn && paddr == `EUR_ADDR_DIVH) divHi <= pwdata[7:0];
      if (wrEn && paddr == `EUR_ADDR_DIVL) divLo <= pwdata[7:0];
      if (wrEn && paddr == `EUR_ADDR_INTC) rxie <= pwdata[`EUR_INTC_RXIE];
    end
  end

  // Baud generator: period divisor+1, extra divide by four in the x64 setting
  assign baseTick   = serial_port_enable && brgCnt == 16'h0;
  assign sampleTick = baseTick && (baud_wide_generator_select || baud_high_speed_select || preCnt == 2'h3);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      brgCnt <= 16'h0;
      preCnt <= 2'h0;
    end else begin
      if (!serial_port_enable || brgCnt == 16'h0)
        brgCnt <= baud_wide_generator_select ? {divHi, divLo} : {8'h00, divLo};
      else
        brgCnt <= brgCnt - 16'h1;
      if (!serial_port_enable)
        preCnt <= 2'h0;
      else if (baseTick)
        preCnt <= preCnt + 2'h1;
    end
  end

  // Line synchroniser; the second stage and its delayed copy rxPrev feed logic
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= serialReceiveLine;
      rxSync <= rxMeta;
      rxPrev <= rxSync;
    end
  end
  assign fallEdge = rxPrev && !rxSync;
  assign riseEdge = !rxPrev && rxSync;

  // Receiver
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxState    <= eur_pkg::RX_IDLE;
      osCnt      <= 4'h0;
      bitCnt     <= 4'h0;
      shiftReg   <= 9'h0;
      stopBit    <= 1'b1;
      doneStrobe <= 1'b0;
      wakeSeen   <= 1'b0;
      wakeEvt    <= 1'b0;
    end else begin
      doneStrobe <= 1'b0;
      wakeEvt    <= 1'b0;
      case (rxState)
        eur_pkg::RX_IDLE: begin
          wakeSeen <= 1'b0;
          if (wake_on_edge_enable)
            rxState <= eur_pkg::RX_WAKE;
          else if (serial_port_enable && continuous_receive_enable && !sync && !overrun_error_flag && fallEdge) begin
            rxState <= eur_pkg::RX_START;
            osCnt   <= 4'h0;
          end
        end
        eur_pkg::RX_START: begin
          if (!continuous_receive_enable)
            rxState <= eur_pkg::RX_IDLE;
          else if (sampleTick) begin
            if (osCnt == `EUR_OS_MID) begin
              // A start bit that is high at mid-bit was a glitch
              rxState <= rxSync ? eur_pkg::RX_IDLE : eur_pkg::RX_DATA;
              osCnt   <= 4'h0;
              bitCnt  <= 4'h0;
            end else
              osCnt <= osCnt + 4'h1;
          end
        end
        eur_pkg::RX_DATA: begin
          if (!continuous_receive_enable)
            rxState <= eur_pkg::RX_IDLE;
          else if (sampleTick) begin
            osCnt <= osCnt + 4'h1;
            if (osCnt == `EUR_OS_LAST) begin
              shiftReg <= {rxSync, shiftReg[8:1]};
              if (bitCnt == (rx9 ? 4'h8 : 4'h7))
                rxState <= eur_pkg::RX_STOP;
              else
                bitCnt <= bitCnt + 4'h1;
            end
          end
        end
        eur_pkg::RX_STOP: begin
          if (!continuous_receive_enable)
            rxState <= eur_pkg::RX_IDLE;
          else if (sampleTick) begin
            osCnt <= osCnt + 4'h1;
            if (osCnt == `EUR_OS_LAST) begin
              stopBit    <= rxSync;
              doneStrobe <= 1'b1;
              rxState    <= eur_pkg::RX_IDLE;
            end
          end
        end
        eur_pkg::RX_WAKE: begin
          // Clocked here; no clockless path exists in this logic
          if (fallEdge && !wakeSeen) begin
            wakeSeen <= 1'b1;
            wakeEvt  <= 1'b1;
          end
          if (!wake_on_edge_enable)
            rxState <= eur_pkg::RX_IDLE;
        end
        default: rxState <= eur_pkg::RX_IDLE;
      endcase
    end
  end

  // Receive buffer, errors and flag
  assign accept = !(address_detect_enable && rx9 && !shiftReg[8]);
  assign setRx  = (doneStrobe && accept && !rxFull) || wakeEvt;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxWord <= '0;
      rxFull <= 1'b0;
      overrun_error_flag   <= 1'b0;
    end else begin
      if (rdEn && paddr == `EUR_ADDR_RXDB)
        rxFull <= 1'b0;
      if (wrEn && paddr == `EUR_ADDR_RXSC && !pwdata[`EUR_RXSC_CONTINUOUS_RECEIVE_ENABLE]) begin
        overrun_error_flag            <= 1'b0;
        rxWord.frameErr <= 1'b0;
      end else if (doneStrobe && accept) begin
        if (rxFull)
          overrun_error_flag <= 1'b1;
        else begin
          rxWord.data     <= rx9 ? shiftReg[7:0] : shiftReg[8:1];
          rxWord.ninth    <= rx9 && shiftReg[8];
          rxWord.frameErr <= !stopBit;
          rxFull          <= 1'b1;
        end
      end
    end
  end

  // Hardware set wins over the clear by a buffer read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxFlag             <= 1'b0;
      rxInterruptRequest <= 1'b0;
    end else begin
      if (setRx)
        rxFlag <= 1'b1;
      else if (rdEn && paddr == `EUR_ADDR_RXDB)
        rxFlag <= 1'b0;
      rxInterruptRequest <= (rxFlag || setRx) && rxie;
    end
  end

  // Transmitter: ordinary frames and Break
  // Frames start on a sample tick, so the start bit lasts a full bit time
  assign txLoad   = txState == eur_pkg::TX_IDLE && txFull && transmit_enable_bit && serial_port_enable && sampleTick;
  assign txBitEnd = txState == eur_pkg::TX_SEND && sampleTick && txOs == `EUR_OS_LAST;
  assign breakEnd = txBitEnd && txLeft == 4'h1 && txIsBreak;

  always_ff @(posedge clk) begin
    if (!nrst)
      txFull <= 1'b0;
    else if (wrEn && paddr == `EUR_ADDR_TXDB)
      txFull <= 1'b1;
    else if (txLoad)
      txFull <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      txData <= 8'h00;
    else if (wrEn && paddr == `EUR_ADDR_TXDB)
      txData <= pwdata[7:0];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      txState            <= eur_pkg::TX_IDLE;
      txShift            <= 14'h3FFF;
      txOs               <= 4'h0;
      txLeft             <= 4'h0;
      txIsBreak          <= 1'b0;
      serialTransmitLine <= 1'b1;
    end else begin
      case (txState)
        eur_pkg::TX_IDLE: begin
          serialTransmitLine <= 1'b1;
          if (txLoad) begin
            txState   <= eur_pkg::TX_SEND;
            txOs      <= 4'h0;
            txIsBreak <= send_break_request;
            if (send_break_request) begin
              txShift <= 14'h2000;
              txLeft  <= `EUR_LEN_BREAK;
            end else if (tx9) begin
              txShift <= {4'hF, tx9d, txData, 1'b0};
              txLeft  <= `EUR_LEN_NINE;
            end else begin
              txShift <= {5'h1F, txData, 1'b0};
              txLeft  <= `EUR_LEN_EIGHT;
            end
          end
        end
        eur_pkg::TX_SEND: begin
          serialTransmitLine <= txShift[0];
          if (sampleTick)
            txOs <= txOs + 4'h1;
          if (txBitEnd) begin
            txShift <= {1'b1, txShift[13:1]};
            txLeft  <= txLeft - 4'h1;
            if (txLeft == 4'h1)
              txState <= eur_pkg::TX_IDLE;
          end
        end
        default: txState <= eur_pkg::TX_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_done_sets_flag;
    (doneStrobe && accept && !rxFull) |=> rxFlag && rxFull;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) else $error("frame lost");

  property p_addr_filter;
    (doneStrobe && address_detect_enable && rx9 && !shiftReg[8]) |=> $stable(rxWord.data) && !$rose(rxFull);
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("data word let in");

  property p_continuous_receive_enable_clear;
    (wrEn && paddr == `EUR_ADDR_RXSC && !pwdata[`EUR_RXSC_CONTINUOUS_RECEIVE_ENABLE])
      |=> !overrun_error_flag && !rxWord.frameErr;
  endproperty
  a_continuous_receive_enable_clear: assert property (p_continuous_receive_enable_clear) else $error("errors kept");

  property p_wue_idle;
    (wake_on_edge_enable && rxState == eur_pkg::RX_IDLE) |=> rxState == eur_pkg::RX_WAKE;
  endproperty
  a_wue_idle: assert property (p_wue_idle) else $error("no wake state");

  property p_wake_flag;
    (rxState == eur_pkg::RX_WAKE && fallEdge && !wakeSeen) |=> ##1 rxFlag;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake not flagged");

  property p_read_clears;
    (rdEn && paddr == `EUR_ADDR_RXDB && !setRx) |=> !rxFlag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag not cleared");

  property p_wue_auto;
    (rxState == eur_pkg::RX_WAKE && wakeSeen && riseEdge && !wrEn)
      |=> !wake_on_edge_enable ##1 rxState == eur_pkg::RX_IDLE;
  endproperty
  a_wue_auto: assert property (p_wue_auto) else $error("wake not ended");

  property p_break_start;
    (txLoad && send_break_request) |=> txLeft == 4'hE && txShift == 14'h2000 ##1 !serialTransmitLine;
  endproperty
  a_break_start: assert property (p_break_start) else $error("bad break");

  property p_send_break_request_clear;
    (breakEnd && !(wrEn && paddr == `EUR_ADDR_TXSC)) |=> !send_break_request && txState == eur_pkg::TX_IDLE;
  endproperty
  a_send_break_request_clear: assert property (p_send_break_request_clear) else $error("send-break kept");

  c_wake: cover property (wakeEvt ##[1:1000] !wake_on_edge_enable);
  c_break: cover property (breakEnd);
  c_addr_drop: cover property (doneStrobe && !accept);
  c_overrun: cover property ($rose(overrun_error_flag));

endmodule

// ==== tb/eur_remote_node.sv ====
`timescale 1ns/1ps
module eur_remote_node #(
  parameter int BIT_CLK = 32,
  parameter int BIT_NS  = 1280
) (
  // Port clock, only used to place line edges
  input  wire logic clk,
  // Line towards the port
  output logic      rxLine,
  // Line from the port
  input  wire logic txLine
);
  initial rxLine = 1'b1;

  // Line edges are launched on the port clock edge by non-blocking assignment
  task automatic send_word(input logic [8:0] w, input int nBits, input logic stopBit);
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (BIT_CLK) @(posedge clk);
    for (int i = 0; i < nBits; i++) begin
      rxLine <= w[i];
      repeat (BIT_CLK) @(posedge clk);
    end
    rxLine <= stopBit;
    repeat (BIT_CLK) @(posedge clk);
    rxLine <= 1'b1;
    repeat (BIT_CLK) @(posedge clk);
  endtask

  // Wake character is all zeros, so no early rising edge ends the wake-up
  task automatic hold_low(input int nClk);
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (nClk) @(posedge clk);
  endtask

  task automatic release_line();
    @(posedge clk);
    rxLine <= 1'b1;
    repeat (BIT_CLK) @(posedge clk);
  endtask

  task automatic measure_low(output int lowNs);
    time t0;
    @(negedge txLine);
    t0 = $time;
    @(posedge txLine);
    lowNs = int'($time - t0);
  endtask

  task automatic recv_byte(output logic [7:0] b);
    @(negedge txLine);
    #(BIT_NS + BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      b[i] = txLine;
      #(BIT_NS);
    end
  endtask
endmodule

// ==== tb/eur_uart_top_tb.sv ====
`timescale 1ns/1ps
`include "eur_defines.svh"
module eur_uart_top_tb;
  // Divisor 1 with x16 sampling gives 32 clocks a bit
  localparam int BIT_CLK = 32;
  localparam int BIT_NS  = BIT_CLK * 40;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire logic   rxLine;
  logic        txLine;
  logic        rxIrq;
  int          errTotal;
  int          comparisons;
  int          lowNs;
  logic [31:0] rdVal;
  logic        errBit;
  logic [7:0]  byteSeen;

  eur_uart_top dut (
    .clk               (clk),
    .nrst              (nrst),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .serialReceiveLine (rxLine),
    .serialTransmitLine(txLine),
    .rxInterruptRequest(rxIrq)
  );

  eur_remote_node #(.BIT_CLK(BIT_CLK), .BIT_NS(BIT_NS)) node (
    .clk   (clk),
    .rxLine(rxLine),
    .txLine(txLine)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, ex, r & m);
  endtask

  task automatic rx(input logic [8:0] w, input int nb, input logic stp, input logic expIrq);
    node.send_word(w, nb, stp);
    repeat (4) @(posedge clk);
    chk("irq", {31'h0, expIrq}, {31'h0, rxIrq});
  endtask

  // Limit is about ten times the expected run
  initial begin
    #(3_000_000);
    errTotal++;
    final_report();
  end

  initial begin
    errTotal    = 0;
    comparisons = 0;
    nrst    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    chk("txIdle", 32'h1, {31'h0, txLine});
    chk("irqReset", 32'h0, {31'h0, rxIrq});
    apb(1'b0, 8'h20, 32'h0, rdVal, errBit);
    chk("slverr", 32'h1, {31'h0, errBit});
    chk("unmapped", 32'h0, rdVal);
    wr(`EUR_ADDR_DIVH, 32'hA5);
    rdchk("divh", `EUR_ADDR_DIVH, 32'hFFFF_FFFF, 32'hA5);
    wr(`EUR_ADDR_DIVH, 32'h00);
    wr(`EUR_ADDR_DIVL, 32'h01);
    wr(`EUR_ADDR_TXSC, 32'h04);
    wr(`EUR_ADDR_BAUD, 32'h00);
    wr(`EUR_ADDR_RXSC, 32'h90);
    wr(`EUR_ADDR_INTC, 32'h10);
    rx(9'h0A5, 8, 1'b1, 1'b1);
    rdchk("rxsc", `EUR_ADDR_RXSC, 32'hFF, 32'h90);
    rdchk("rxdb", `EUR_ADDR_RXDB, 32'hFF, 32'hA5);
    rdchk("rxFlag", `EUR_ADDR_INTC, 32'h01, 32'h00);
    wr(`EUR_ADDR_INTC, 32'h00);
    rx(9'h03C, 8, 1'b1, 1'b0);
    rdchk("rxFlag", `EUR_ADDR_INTC, 32'h01, 32'h01);
    rdchk("rxdb", `EUR_ADDR_RXDB, 32'hFF, 32'h3C);
    wr(`EUR_ADDR_INTC, 32'h10);
    rx(9'h00F, 8, 1'b0, 1'b1);
    rdchk("framing_error_flag", `EUR_ADDR_RXSC, 32'hFF, 32'h94);
    rdchk("rxdb", `EUR_ADDR_RXDB, 32'hFF, 32'h0F);
    wr(`EUR_ADDR_RXSC, 32'h80);
    rdchk("ferrClr", `EUR_ADDR_RXSC, 32'hFF, 32'h80);
    wr(`EUR_ADDR_RXSC, 32'h90);
    rx(9'h011, 8, 1'b1, 1'b1);
    rx(9'h022, 8, 1'b1, 1'b1);
    rdchk("overrun_error_flag", `EUR_ADDR_RXSC, 32'hFF, 32'h92);
    rdchk("rxdb", `EUR_ADDR_RXDB, 32'hFF, 32'h11);
    wr(`EUR_ADDR_RXSC, 32'h80);
    rx(9'h077, 8, 1'b1, 1'b0);
    rdchk("oerrClr", `EUR_ADDR_RXSC, 32'hFF, 32'h80);
    wr(`EUR_ADDR_RXSC, 32'hD8);
    rx(9'h042, 9, 1'b1, 1'b0);
    rx(9'h105, 9, 1'b1, 1'b1);
    rdchk("ninth", `EUR_ADDR_RXSC, 32'hFF, 32'hD9);
    rdchk("rxdb", `EUR_ADDR_RXDB, 32'hFF, 32'h05);
    wr(`EUR_ADDR_RXSC, 32'hD0);
    rx(9'h099, 9, 1'b1, 1'b1);
    rdchk("ninth", `EUR_ADDR_RXSC, 32'hFF, 32'hD0);
    rdchk("rxdb", `EUR_ADDR_RXDB, 32'hFF, 32'h99);
    wr(`EUR_ADDR_RXSC, 32'h90);
    rdchk("receiver_idle_status", `EUR_ADDR_BAUD, 32'h40, 32'h40);
    wr(`EUR_ADDR_BAUD, 32'h02);
    node.hold_low(13 * BIT_CLK);
    chk("wakeIrq", 32'h1, {31'h0, rxIrq});
    rdchk("wueHeld", `EUR_ADDR_BAUD, 32'h02, 32'h02);
    node.release_line();
    rdchk("wueClr", `EUR_ADDR_BAUD, 32'h02, 32'h00);
    rdchk("noFerr", `EUR_ADDR_RXSC, 32'hFF, 32'h90);
    rdchk("rxdbKept", `EUR_ADDR_RXDB, 32'hFF, 32'h99);
    repeat (2) @(posedge clk);
    chk("wakeClr", 32'h0, {31'h0, rxIrq});
    rx(9'h055, 8, 1'b1, 1'b1);
    rdchk("rxdb", `EUR_ADDR_RXDB, 32'hFF, 32'h55);
    // Break at nine thirteenths speed: receiver bit 208 clocks, sender bit 144
    wr(`EUR_ADDR_DIVL, 32'h0C);
    node.hold_low(13 * 144);
    node.release_line();
    repeat (8 * BIT_CLK) @(posedge clk);
    chk("breakIrq", 32'h1, {31'h0, rxIrq});
    rdchk("breakSts", `EUR_ADDR_RXSC, 32'hFF, 32'h90);
    rdchk("breakData", `EUR_ADDR_RXDB, 32'hFF, 32'h00);
    wr(`EUR_ADDR_DIVL, 32'h01);
    wr(`EUR_ADDR_TXSC, 32'h24);
    fork
      node.recv_byte(byteSeen);
      wr(`EUR_ADDR_TXDB, 32'hC3);
    join
    chk("txByte", 32'hC3, {24'h0, byteSeen});
    repeat (2 * BIT_CLK) @(posedge clk);
    fork
      node.measure_low(lowNs);
      begin
        wr(`EUR_ADDR_TXSC, 32'h2C);
        wr(`EUR_ADDR_TXDB, 32'hFF);
        wr(`EUR_ADDR_TXDB, 32'h55);
        rdchk("txscBreak", `EUR_ADDR_TXSC, 32'hFF, 32'h2C);
      end
    join
    chk("breakLow", 32'(13 * BIT_NS), 32'(lowNs));
    node.recv_byte(byteSeen);
    chk("syncByte", 32'h55, {24'h0, byteSeen});
    repeat (2 * BIT_CLK) @(posedge clk);
    rdchk("txscEnd", `EUR_ADDR_TXSC, 32'hFF, 32'h26);
    rdchk("txFlag", `EUR_ADDR_INTC, 32'h02, 32'h02);
    wr(`EUR_ADDR_BAUD, 32'h01);
    rdchk("autobaud_detect_enable", `EUR_ADDR_BAUD, 32'h43, 32'h41);
    final_report();
  end
endmodule
